// ---- rtl/spb_bank.sv ----
// spb_bank: holding registers and internal copies for tone profiles 4..7 plus user word.
// assumes: host port logic on mclk_in; update, profile, lock and reset pins are asynchronous.
// Functional notes
// - four 32-bit tuning words at 0x13..0x19
// - byte mode, four bytes per word, low first
// - phase offset in bits 15:0
// - amplitude scale in bits 27:16, top open
// - profile registers have no reset value
// - master reset restores register defaults
// - enable rising edge starts calibration
// - flag operation without completed calibration
// - values apply on update or profile change
// - address space 0x00..0x1B, 112 bytes
`timescale 1ns/1ns
module spb_bank import spb_pkg::*; #(
   parameter int unsigned CAL_CYCLES = SPB_CAL_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic master_reset_pin_in,
   input wire logic io_update_pin_in,
   input wire logic [2:0] profile_select_pins_in,
   input wire logic pll_lock_in,
   input wire logic cal_enable_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic word_mode_in,
   input wire logic [6:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [127:0] low_tune_in,
   input wire logic [127:0] low_pa_in,
   output logic [31:0] rdata_out,
   output logic [31:0] active_tune_out,
   output logic [15:0] active_phase_out,
   output logic [11:0] active_amp_out,
   output logic [23:0] user_fixed_out,
   output logic cal_busy_out,
   output logic cal_done_out,
   output logic uncal_flag_out
);
   logic [1:0] mrst_sync;
   logic [1:0] upd_sync;
   logic [1:0] lock_sync;
   logic [2:0] ps_meta;
   logic [2:0] ps_sel;
   logic [2:0] ps_prev;
   logic upd_prev;
   logic cal_en_prev;
   logic mrst;
   logic apply;
   logic [4:0] waddr;
   logic [1:0] lane;
   logic [3:0] widx;
   logic in_bank;
   logic [31:0] lane_mask;
   logic [31:0] wdata_rep;
   logic [31:0] hold [SPB_NUM_REGS];
   logic [31:0] int_tune [SPB_NUM_UPPER];
   logic [31:0] int_pa [SPB_NUM_UPPER];
   logic [31:0] sel_tune;
   logic [31:0] sel_pa;
   logic [31:0] rd_word;
   logic copies_loaded;
   spb_cal_if cal ();

   // pins cross in through two flops; only the second stage is read
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mrst_sync <= 2'h0;
         upd_sync <= 2'h0;
         lock_sync <= 2'h0;
         ps_meta <= 3'h0;
         ps_sel <= 3'h0;
      end else begin
         mrst_sync <= {mrst_sync[0], master_reset_pin_in};
         upd_sync <= {upd_sync[0], io_update_pin_in};
         lock_sync <= {lock_sync[0], pll_lock_in};
         ps_meta <= profile_select_pins_in;
         ps_sel <= ps_meta;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         upd_prev <= 1'b0;
         ps_prev <= 3'h0;
         cal_en_prev <= 1'b0;
      end else begin
         upd_prev <= upd_sync[1];
         ps_prev <= ps_sel;
         cal_en_prev <= cal_enable_in;
      end
   end

   assign mrst = mrst_sync[1];
   assign apply = (upd_sync[1] && !upd_prev) || (ps_sel != ps_prev);

   // word mode: one address per register; byte mode: four per register
   always_comb begin
      waddr = word_mode_in ? addr_in[4:0] : addr_in[6:2];
      lane = addr_in[1:0];
      in_bank = (waddr >= SPB_ADDR_P4_TUNE) && (waddr <= SPB_ADDR_LAST)
         && (word_mode_in ? (addr_in[6:5] == 2'h0) : (addr_in <= SPB_BYTE_LAST));
      widx = 4'(waddr - SPB_ADDR_P4_TUNE);
      lane_mask = word_mode_in ? 32'hffff_ffff : (32'h0000_00ff << {lane, 3'h0});
      wdata_rep = word_mode_in ? wdata_in : {4{wdata_in[7:0]}};
   end

   for (genvar g = 0; g < SPB_NUM_REGS; g++) begin : g_hold
      localparam logic [31:0] FIELD_MASK = (g == SPB_NUM_REGS - 1) ? SPB_USER_MASK :
         ((g % 2 == 0) ? SPB_TUNE_MASK : SPB_PA_MASK);
      logic [31:0] m;
      assign m = lane_mask & FIELD_MASK;
      if (g == SPB_NUM_REGS - 1) begin : g_user
         always_ff @(posedge mclk_in) begin
            if (rst_in || mrst) begin
               hold[g] <= SPB_USER_DEFAULT;
            end else if (wr_en_in && in_bank && widx == 4'(g)) begin
               hold[g] <= (hold[g] & ~m) | (wdata_rep & m);
            end
         end
      end else begin : g_prof
         // no reset: contents are undefined until the host writes them
         always_ff @(posedge mclk_in) begin
            if (wr_en_in && in_bank && widx == 4'(g)) begin
               hold[g] <= (hold[g] & ~m) | (wdata_rep & m);
            end
         end
      end
   end

   // holding buffers reach internal copies only on update or profile change
   always_ff @(posedge mclk_in) begin
      if (apply) begin
         for (int i = 0; i < SPB_NUM_UPPER; i++) begin
            int_tune[i] <= hold[2 * i];
            int_pa[i] <= hold[2 * i + 1];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in || mrst) begin
         user_fixed_out <= SPB_USER_DEFAULT[23:0];
      end else if (apply) begin
         user_fixed_out <= hold[SPB_USER_IDX][23:0];
      end
   end

   always_comb begin
      if (ps_sel[2]) begin
         sel_tune = int_tune[ps_sel[1:0]];
         sel_pa = int_pa[ps_sel[1:0]];
      end else begin
         sel_tune = low_tune_in[{ps_sel[1:0], 5'h00} +: 32];
         sel_pa = low_pa_in[{ps_sel[1:0], 5'h00} +: 32];
      end
   end

   // one cycle behind the select; the copy its apply loads reaches the outputs one cycle after the pin change does
   always_ff @(posedge mclk_in) begin
      if (rst_in || mrst) begin
         active_tune_out <= 32'h0000_0000;
         active_phase_out <= 16'h0000;
         active_amp_out <= 12'h000;
      end else begin
         active_tune_out <= sel_tune;
         active_phase_out <= sel_pa[SPB_POW_LSB +: SPB_POW_W];
         active_amp_out <= sel_pa[SPB_ASF_LSB +: SPB_ASF_W];
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (in_bank) begin
         rd_word = hold[widx];
         if (widx == SPB_USER_IDX) begin
            rd_word[SPB_LOCK_BIT] = lock_sync[1];
         end
      end
   end

   // addresses of other blocks answer zero here
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_en_in) begin
         rdata_out <= word_mode_in ? rd_word : {24'h00_0000, rd_word[{lane, 3'h0} +: 8]};
      end
   end

   assign cal.start = cal_enable_in && !cal_en_prev;
   assign cal.clear = mrst;

   spb_cal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .cal(cal)
   );

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cal_busy_out <= 1'b0;
         cal_done_out <= 1'b0;
      end else begin
         cal_busy_out <= cal.busy;
         cal_done_out <= cal.done;
      end
   end

   // sticky; a new apply in the clearing cycle still sets it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         uncal_flag_out <= 1'b0;
      end else if (apply && !cal.done) begin
         uncal_flag_out <= 1'b1;
      end else if (mrst) begin
         uncal_flag_out <= 1'b0;
      end
   end

   // copies are undefined until the first apply; stability means nothing before it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         copies_loaded <= 1'b0;
      end else if (apply) begin
         copies_loaded <= 1'b1;
      end
   end

   word_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      wr_en_in && word_mode_in && addr_in == 7'h13 |=> hold[0] == $past(wdata_in))
      else $error("word write to tuning register lost");
   byte_lane_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      wr_en_in && !word_mode_in && addr_in == 7'h4d |=> hold[0][15:8] == $past(wdata_in[7:0]))
      else $error("byte write landed in wrong lane");
   phase_field_a: assert property (@(posedge mclk_in) disable iff (rst_in || mrst)
      ps_sel == 3'h4 |=> active_phase_out == $past(int_pa[0][15:0]))
      else $error("phase offset field wrong");
   amp_field_a: assert property (@(posedge mclk_in) disable iff (rst_in || mrst)
      ps_sel == 3'h6 |=> active_amp_out == $past(int_pa[2][27:16]))
      else $error("amplitude field wrong");
   master_default_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      mrst |=> hold[8] == SPB_USER_DEFAULT && user_fixed_out == 24'h00_0800)
      else $error("master reset left user word changed");
   cal_start_a: assert property (@(posedge mclk_in) disable iff (rst_in || mrst)
      cal.start && !cal.busy |=> cal.busy [*2] ##[0:64] cal.done)
      else $error("calibration did not run");
   uncal_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      apply && !cal.done |=> uncal_flag_out)
      else $error("uncalibrated operation not flagged");
   hold_apply_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      copies_loaded && !apply |=> $stable(int_tune[1]) && $stable(int_pa[3]))
      else $error("internal copy changed without update");
   unmapped_rd_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      rd_en_in && word_mode_in && addr_in == 7'h12 |=> rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   lock_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      rd_en_in && word_mode_in && addr_in == 7'h1b
      |=> rdata_out[31:25] == 7'h00 && rdata_out[24] == $past(lock_sync[1]))
      else $error("user word top byte wrong");
   profile_sel_a: assert property (@(posedge mclk_in) disable iff (rst_in || mrst)
      ps_sel == 3'h5 |=> active_tune_out == $past(int_tune[1]))
      else $error("profile select picked wrong tuning word");
   cov_update_c: cover property (@(posedge mclk_in) upd_sync[1] && !upd_prev);
   cov_profile_c: cover property (@(posedge mclk_in) ps_sel[2] && ps_sel != ps_prev);
   cov_cal_c: cover property (@(posedge mclk_in) cal.busy ##1 cal.done);
endmodule : spb_bank

// ---- rtl/spb_pkg.sv ----
// spb_pkg: constants for the upper-profile register bank.
// assumes: serial word addresses 0x00..0x1B, byte addresses four per word.
package spb_pkg;
   localparam int unsigned SPB_NUM_REGS = 9;
   localparam int unsigned SPB_NUM_UPPER = 4;
   localparam logic [4:0] SPB_ADDR_P4_TUNE = 5'h13;
   localparam logic [4:0] SPB_ADDR_P4_PA = 5'h14;
   localparam logic [4:0] SPB_ADDR_P5_TUNE = 5'h15;
   localparam logic [4:0] SPB_ADDR_P5_PA = 5'h16;
   localparam logic [4:0] SPB_ADDR_P6_TUNE = 5'h17;
   localparam logic [4:0] SPB_ADDR_P6_PA = 5'h18;
   localparam logic [4:0] SPB_ADDR_P7_TUNE = 5'h19;
   localparam logic [4:0] SPB_ADDR_P7_PA = 5'h1a;
   localparam logic [4:0] SPB_ADDR_USER = 5'h1b;
   localparam logic [4:0] SPB_ADDR_LAST = 5'h1b;
   localparam logic [6:0] SPB_BYTE_LAST = 7'h6f;
   localparam logic [3:0] SPB_USER_IDX = 4'h8;
   localparam int unsigned SPB_POW_LSB = 0;
   localparam int unsigned SPB_POW_W = 16;
   localparam int unsigned SPB_ASF_LSB = 16;
   localparam int unsigned SPB_ASF_W = 12;
   localparam int unsigned SPB_LOCK_BIT = 24;
   localparam logic [31:0] SPB_TUNE_MASK = 32'hffff_ffff;
   localparam logic [31:0] SPB_PA_MASK = 32'h0fff_ffff;
   localparam logic [31:0] SPB_USER_MASK = 32'h00ff_ffff;
   localparam logic [31:0] SPB_USER_DEFAULT = 32'h0000_0800;
   localparam int unsigned SPB_CAL_CYCLES = 16;
   typedef enum logic [2:0] {
      SPB_CAL_IDLE = 3'b001,
      SPB_CAL_RUN = 3'b010,
      SPB_CAL_DONE = 3'b100
   } spb_cal_state_t;
endpackage : spb_pkg

// ---- rtl/spb_cal_if.sv ----
// spb_cal_if: start/clear and status between bank and calibration engine.
// assumes: both ends run on the same clock.
`timescale 1ns/1ns
interface spb_cal_if;
   logic start;
   logic clear;
   logic busy;
   logic done;
   modport engine (input start, input clear, output busy, output done);
   modport ctrl (output start, output clear, input busy, input done);
endinterface : spb_cal_if

// ---- rtl/spb_cal_engine.sv ----
// spb_cal_engine: converter timing calibration sequencer.
// assumes: start is a one-cycle pulse on the rising edge of the enable bit.
`timescale 1ns/1ns
module spb_cal_engine import spb_pkg::*; #(
   parameter int unsigned CAL_CYCLES = SPB_CAL_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   spb_cal_if.engine cal
);
   spb_cal_state_t state;
   logic [15:0] count;

   assign cal.busy = (state == SPB_CAL_RUN);
   assign cal.done = (state == SPB_CAL_DONE);

   always_ff @(posedge mclk_in) begin
      if (rst_in || cal.clear) begin
         state <= SPB_CAL_IDLE;
         count <= 16'h0000;
      end else begin
         case (state)
            SPB_CAL_IDLE, SPB_CAL_DONE: begin
               if (cal.start) begin
                  state <= SPB_CAL_RUN;
                  count <= 16'(CAL_CYCLES - 1);
               end
            end
            SPB_CAL_RUN: begin
               // a restart during the run is ignored; the run finishes first
               if (count == 16'h0000) begin
                  state <= SPB_CAL_DONE;
               end else begin
                  count <= count - 16'h0001;
               end
            end
            default: state <= SPB_CAL_IDLE;
         endcase
      end
   end
endmodule : spb_cal_engine

// ---- testbench/spb_host_model.sv ----
// spb_host_model: host controller on the register port, plus power-up duties.
// assumes: bank samples on rising mclk_in; host moves its lines at falling edges.
`timescale 1ns/1ns
module spb_host_model (
   input wire logic mclk_in,
   input wire logic [31:0] rdata_in,
   output logic master_reset_out,
   output logic cal_enable_out,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic word_mode_out,
   output logic [6:0] addr_out,
   output logic [31:0] wdata_out
);
   initial begin
      master_reset_out = 1'b0;
      cal_enable_out = 1'b0;
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      word_mode_out = 1'b1;
      addr_out = 7'h00;
      wdata_out = 32'h0000_0000;
   end
   // released lines get inverted values so nothing relies on stale data
   task automatic wr(input logic mode, input logic [6:0] a, input logic [31:0] d);
      @(negedge mclk_in);
      word_mode_out = mode;
      addr_out = a;
      wdata_out = d;
      wr_en_out = 1'b1;
      @(negedge mclk_in);
      wr_en_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : wr
   task automatic rd(input logic mode, input logic [6:0] a, output logic [31:0] d);
      @(negedge mclk_in);
      word_mode_out = mode;
      addr_out = a;
      rd_en_out = 1'b1;
      @(negedge mclk_in);
      rd_en_out = 1'b0;
      addr_out = ~a;
      d = rdata_in;
   endtask : rd
   task automatic user_default();
      wr(1'b1, 7'h1b, 32'h0000_0800);
   endtask : user_default
   task automatic master_reset();
      @(negedge mclk_in);
      master_reset_out = 1'b1;
      repeat (4) @(negedge mclk_in);
      master_reset_out = 1'b0;
   endtask : master_reset
   // enable must fall again before any later calibration can start
   task automatic cal_toggle();
      @(negedge mclk_in);
      cal_enable_out = 1'b1;
      repeat (2) @(negedge mclk_in);
      cal_enable_out = 1'b0;
   endtask : cal_toggle
endmodule : spb_host_model

// ---- testbench/tb.sv ----
// tb: self-checking bench for the upper-profile register bank.
// assumes: host model owns the register port; bench drives pins at falling edges.
`timescale 1ns/1ns
module tb;
   import spb_pkg::*;
   localparam int unsigned CAL_N = 4;
   typedef struct packed {
      logic mode;
      logic [6:0] a;
      logic [31:0] d;
      logic [31:0] exp;
   } spb_tb_row_t;
   logic mclk_in, rst_in, mres, upd, lock, cal_en, wr_en, rd_en, wmode;
   logic c_busy, c_done, uncal;
   logic [2:0] psel;
   logic [6:0] addr;
   logic [31:0] wdata, rdata, a_tune, rv;
   logic [15:0] a_phase;
   logic [11:0] a_amp;
   logic [23:0] ufix;
   logic [127:0] lo_tune, lo_pa;
   int fails, samples_checked, nb;
   spb_tb_row_t rows [0:9] = '{
      {1'b1, 7'h13, 32'h1234_5678, 32'h1234_5678},
      {1'b1, 7'h19, 32'h8765_4321, 32'h8765_4321},
      {1'b1, 7'h14, 32'hffff_ffff, 32'h0fff_ffff},
      {1'b1, 7'h1a, 32'ha5a5_5a5a, 32'h05a5_5a5a},
      {1'b0, 7'h4d, 32'h0000_00c3, 32'h0000_00c3},
      {1'b0, 7'h6b, 32'h0000_00ff, 32'h0000_000f},
      {1'b1, 7'h12, 32'hdead_beef, 32'h0000_0000},
      {1'b0, 7'h70, 32'h0000_0011, 32'h0000_0000},
      {1'b1, 7'h1b, 32'h0000_0800, 32'h0100_0800},
      {1'b0, 7'h6f, 32'h0000_00ff, 32'h0000_0001}};
   spb_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .master_reset_out(mres),
      .cal_enable_out(cal_en), .wr_en_out(wr_en), .rd_en_out(rd_en),
      .word_mode_out(wmode), .addr_out(addr), .wdata_out(wdata));
   spb_bank #(.CAL_CYCLES(CAL_N)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
      .master_reset_pin_in(mres), .io_update_pin_in(upd),
      .profile_select_pins_in(psel), .pll_lock_in(lock), .cal_enable_in(cal_en),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .word_mode_in(wmode), .addr_in(addr),
      .wdata_in(wdata), .low_tune_in(lo_tune), .low_pa_in(lo_pa), .rdata_out(rdata),
      .active_tune_out(a_tune), .active_phase_out(a_phase), .active_amp_out(a_amp),
      .user_fixed_out(ufix), .cal_busy_out(c_busy), .cal_done_out(c_done),
      .uncal_flag_out(uncal));
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // apply path is sync, apply, copy, output: well inside eight cycles
   task automatic settle();
      repeat (8) @(negedge mclk_in);
   endtask : settle
   task automatic pulse_update();
      @(negedge mclk_in);
      upd = 1'b1;
      repeat (3) @(negedge mclk_in);
      upd = 1'b0;
      settle();
   endtask : pulse_update
   task automatic select(input logic [2:0] p);
      @(negedge mclk_in);
      psel = p;
      settle();
   endtask : select
   initial begin
      rst_in = 1'b1;
      upd = 1'b0;
      lock = 1'b1;
      psel = 3'h0;
      lo_tune = {32'h3333_3333, 32'h2222_2222, 32'h1111_1111, 32'h0000_0001};
      lo_pa = {32'h0333_3003, 32'h0222_2002, 32'h0111_1001, 32'h0000_0000};
      fails = 0;
      samples_checked = 0;
      repeat (10) @(negedge mclk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge mclk_in);
      chk({8'h00, ufix}, 32'h0000_0800);
      chk({rdata[28:0], c_busy, c_done, uncal}, 32'h0000_0000);
      // profile words are undefined until written, so load every one first
      for (int i = 0; i < 8; i++) begin
         host.wr(1'b1, 7'h13 + 7'(i), 32'(7'h13 + 7'(i)));
      end
      host.user_default();
      pulse_update();
      chk({31'h0, uncal}, 32'h0000_0001);
      host.master_reset();
      settle();
      chk({7'h00, uncal, ufix}, 32'h0000_0800);
      host.cal_toggle();
      nb = 0;
      for (int i = 0; i < 40 && c_done !== 1'b1; i++) begin
         if (c_busy === 1'b1) nb++;
         @(negedge mclk_in);
      end
      chk({c_done, 31'(nb)}, {1'b1, 31'(CAL_N)});
      for (int i = 0; i < 10; i++) begin
         host.wr(rows[i].mode, rows[i].a, rows[i].d);
         host.rd(rows[i].mode, rows[i].a, rv);
         chk(rv, rows[i].exp);
      end
      host.rd(1'b1, 7'h13, rv);
      chk(rv, 32'h1234_c378);
      lock = 1'b0;
      settle();
      host.rd(1'b1, 7'h1b, rv);
      chk(rv, 32'h0000_0800);
      @(negedge mclk_in);
      psel = 3'h4;
      pulse_update();
      chk(a_tune, 32'h1234_c378);
      chk({4'h0, a_amp, a_phase}, 32'h0fff_ffff);
      chk({31'h0, uncal}, 32'h0000_0000);
      host.wr(1'b1, 7'h13, 32'h0000_0001);
      settle();
      chk(a_tune, 32'h1234_c378);
      select(3'h7);
      chk(a_tune, 32'h8765_4321);
      chk({4'h0, a_amp, a_phase}, 32'h0fa5_5a5a);
      select(3'h2);
      chk(a_tune, 32'h2222_2222);
      chk({4'h0, a_amp, a_phase}, 32'h0222_2002);
      select(3'h5);
      chk(a_tune, 32'h0000_0015);
      select(3'h6);
      chk({4'h0, a_amp, a_phase}, 32'h0000_0018);
      select(3'h4);
      chk(a_tune, 32'h0000_0001);
      chk({8'h00, ufix}, 32'h0000_0800);
      give_verdict();
   end
endmodule : tb
